/* src/ave_defs.svh */
// Constants of the analog value encoder: fixed codes, band limits, scaling.
// Assumes nothing; included by the encoder and the top files by bare name.
`ifndef AVE_DEFS_SVH
`define AVE_DEFS_SVH

`define AVE_WORD_W 16
`define AVE_SIGN_POS 15
`define AVE_LSB_MASK 16'hfff0
`define AVE_CODE_ZERO 16'h0000
`define AVE_CODE_NOM 16'h6c00
`define AVE_CODE_OVR_MAX 16'h7eff
`define AVE_CODE_OVERFLOW 16'h7fff
`define AVE_CODE_UNDERFLOW 16'h8000
`define AVE_CODE_PARAM_ERR 16'h7fff
`define AVE_CODE_UDR_BIP 16'h8100
`define AVE_CODE_UDR_UNI 16'hed00
`define AVE_RAW_FULL 16384
`define AVE_GAIN_SHIFT 16
`define AVE_LZ_FULL_MA 20
`define AVE_LZ_SPAN_MA 16
`define AVE_LZ_OFS_MA 4
`define AVE_RANGE_W 4
`define AVE_RES_NCH 4
`define AVE_AO_NCH 2

`endif

/* src/ave_pkg.sv */
// Types shared by the analog value encoder files.
// Assumes the range codes below are what the channel configuration holds.
package ave_pkg;

  typedef enum logic [3:0] {
    AVE_R_OFF = 4'h0,
    AVE_R_V_BIP = 4'h1,
    AVE_R_V_UNI = 4'h2,
    AVE_R_I_BIP = 4'h3,
    AVE_R_I_UNI = 4'h4,
    AVE_R_I_LZ = 4'h5,
    AVE_R_RES = 4'h6
  } ave_range_type;

  typedef enum logic [1:0] {
    AVE_F_OK = 2'b00,
    AVE_F_OVER = 2'b01,
    AVE_F_UNDER = 2'b10,
    AVE_F_PERR = 2'b11
  } ave_flag_type;

  typedef enum logic [1:0] {
    AVE_S_IDLE = 2'b00,
    AVE_S_CALC = 2'b01,
    AVE_S_STORE = 2'b10
  } ave_state_type;

endpackage : ave_pkg

/* src/ave_enc_if.sv */
// Carrier between the encoder core and its user.
// Assumes a purely combinational encoder on the far side.
`timescale 1ns/1ps
interface ave_enc_if;
  import ave_pkg::*;
  logic signed [15:0] raw;
  ave_range_type range;
  logic perr;
  logic [15:0] code;
  ave_flag_type flag;
  modport enc (input raw, input range, input perr, output code, output flag);
  modport user (output raw, output range, output perr, input code, input flag);
endinterface : ave_enc_if

/* src/ave_encoder.sv */
// Combinational scaling and band limiting of one raw conversion sample.
// Assumes raw counts where RAW_FULL equals 10 V, 20 mA or 600 ohm.
`timescale 1ns/1ps
`include "ave_defs.svh"
module ave_encoder #(
  parameter int RAW_FULL = `AVE_RAW_FULL
) (
  ave_enc_if.enc e
);
  import ave_pkg::*;

  localparam longint GAIN = (longint'(`AVE_CODE_NOM) <<< `AVE_GAIN_SHIFT) / RAW_FULL;
  localparam longint GAIN_LZ = ((longint'(`AVE_CODE_NOM) <<< `AVE_GAIN_SHIFT) *
    `AVE_LZ_FULL_MA) / (`AVE_LZ_SPAN_MA * RAW_FULL);
  localparam logic signed [16:0] LZ_OFS = 17'((RAW_FULL * `AVE_LZ_OFS_MA) / `AVE_LZ_FULL_MA);
  localparam logic signed [31:0] LIM_HI = 32'($signed(`AVE_CODE_OVR_MAX));
  localparam logic signed [31:0] LIM_BIP = 32'($signed(`AVE_CODE_UDR_BIP));
  localparam logic signed [31:0] LIM_UNI = 32'($signed(`AVE_CODE_UDR_UNI));

  if (RAW_FULL < 256 || RAW_FULL > 32767) begin : g_bad_full
    $error("ave_encoder: RAW_FULL out of range");
  end

  // Live-zero: take away the 4 mA share first
  wire is_lz = (e.range == AVE_R_I_LZ);
  wire signed [16:0] lin = is_lz ? (17'(e.raw) - LZ_OFS) : 17'(e.raw);
  wire signed [25:0] gain = is_lz ? 26'(GAIN_LZ) : 26'(GAIN);
  // Linear scale to 27648 at nominal top
  wire signed [47:0] prod = 48'(lin) * 48'(gain);
  wire signed [31:0] scaled = 32'(prod >>> `AVE_GAIN_SHIFT);

  wire known = (e.range == AVE_R_V_BIP) || (e.range == AVE_R_V_UNI) ||
    (e.range == AVE_R_I_BIP) || (e.range == AVE_R_I_UNI) || is_lz ||
    (e.range == AVE_R_RES) || (e.range == AVE_R_OFF);
  wire is_bip = (e.range == AVE_R_V_BIP) || (e.range == AVE_R_I_BIP);
  wire is_res = (e.range == AVE_R_RES);
  // Underdrive floor per range
  wire signed [31:0] lim_lo = is_bip ? LIM_BIP : (is_res ? 32'sd0 : LIM_UNI);

  always_comb begin
    e.code = `AVE_CODE_ZERO;
    e.flag = AVE_F_OK;
    if (e.perr || !known) begin
      e.code = `AVE_CODE_PARAM_ERR;
      e.flag = AVE_F_PERR;
    end else if (e.range == AVE_R_OFF) begin
      e.code = `AVE_CODE_ZERO;
    end else if (scaled > LIM_HI) begin
      e.code = `AVE_CODE_OVERFLOW;
      e.flag = AVE_F_OVER;
    end else if (is_res && scaled < 32'sd0) begin
      e.code = `AVE_CODE_ZERO;
    end else if (scaled < lim_lo) begin
      e.code = `AVE_CODE_UNDERFLOW;
      e.flag = AVE_F_UNDER;
    end else begin
      e.code = scaled[15:0] & `AVE_LSB_MASK;
    end
  end

endmodule : ave_encoder

/* src/ave_top.sv */
// Analog value encoder: raw conversions in, 16-bit process words out.
// Assumes a converter front end giving one sample per handshake and a
// process-image reader polling words bytewise; one clock, sync reset.
`timescale 1ns/1ps
`include "ave_defs.svh"
module ave_top #(
  parameter int NCH = `AVE_RES_NCH,
  parameter int NAO = `AVE_AO_NCH,
  parameter int RAW_FULL = `AVE_RAW_FULL
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire logic [$clog2(NCH)-1:0] conv_chan,
  input wire logic signed [15:0] conv_raw,
  input wire logic [NCH*`AVE_RANGE_W-1:0] chan_range,
  input wire logic [NCH-1:0] param_busy,
  output logic res_valid,
  output logic [$clog2(NCH)-1:0] res_chan,
  output logic [15:0] res_word,
  output ave_pkg::ave_flag_type res_flag,
  input wire logic [$clog2(NCH)-1:0] rd_chan,
  input wire logic rd_byte_sel,
  output logic [7:0] rd_data,
  output logic [NCH-1:0] sign_bit,
  input wire logic [NAO*16-1:0] ao_word,
  input wire logic [NAO*`AVE_RANGE_W-1:0] ao_type,
  output logic [NAO*16-1:0] ao_dac,
  output logic [NAO-1:0] ao_zero
);
  import ave_pkg::*;

  localparam int CW = $clog2(NCH);

  if (NCH < 2 || NCH > 16) begin : g_bad_nch
    $error("ave_top: NCH must be 2 to 16");
  end
  if (NAO < 1 || NAO > 16) begin : g_bad_nao
    $error("ave_top: NAO must be 1 to 16");
  end

  ave_state_type state_r;
  ave_state_type state_nxt;
  logic signed [15:0] raw_r;
  logic [CW-1:0] chan_r;
  ave_range_type range_r;
  logic perr_r;
  logic [15:0] code_r;
  ave_flag_type flag_r;
  logic conv_ready_r;
  logic res_valid_r;
  logic [CW-1:0] res_chan_r;
  logic [15:0] res_word_r;
  ave_flag_type res_flag_r;
  logic [7:0] rd_data_r;
  logic [15:0] res_mem_r [NCH];
  logic [NCH-1:0] sign_bit_r;
  logic [NAO*16-1:0] ao_dac_r;
  logic [NAO-1:0] ao_zero_r;

  ave_enc_if enc_bus ();

  ave_encoder #(
    .RAW_FULL(RAW_FULL)
  ) u_enc (
    .e(enc_bus)
  );

  // Sample accepted only in idle; one sample in flight
  wire take = conv_valid && (state_r == AVE_S_IDLE);
  wire [`AVE_RANGE_W-1:0] sel_range = chan_range[conv_chan*`AVE_RANGE_W +: `AVE_RANGE_W];
  wire sel_busy = param_busy[conv_chan];
  wire [15:0] rd_word = res_mem_r[rd_chan];
  wire [7:0] rd_byte = rd_byte_sel ? rd_word[7:0] : rd_word[15:8];

  assign enc_bus.raw = raw_r;
  assign enc_bus.range = range_r;
  assign enc_bus.perr = perr_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AVE_S_IDLE: begin
        if (conv_valid) begin
          state_nxt = AVE_S_CALC;
        end
      end
      AVE_S_CALC: begin
        state_nxt = AVE_S_STORE;
      end
      AVE_S_STORE: begin
        state_nxt = AVE_S_IDLE;
      end
      default: begin
        state_nxt = AVE_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= AVE_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Capture stage; the range is frozen with the sample
  // No queue: a sample offered while busy waits at the source
  wire signed [15:0] raw_nxt = take ? conv_raw : raw_r;
  wire [CW-1:0] chan_nxt = take ? conv_chan : chan_r;
  wire [`AVE_RANGE_W-1:0] range_nxt = take ? sel_range : range_r;
  wire perr_nxt = take ? sel_busy : perr_r;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      raw_r <= 16'h0000;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chan_r <= '0;
    end else begin
      chan_r <= chan_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      range_r <= AVE_R_OFF;
    end else begin
      range_r <= ave_range_type'(range_nxt);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      perr_r <= 1'b0;
    end else begin
      perr_r <= perr_nxt;
    end
  end

  // Encoder result registered to break the multiplier path
  wire calc = (state_r == AVE_S_CALC);
  wire [15:0] code_nxt = calc ? enc_bus.code : code_r;
  wire [1:0] flag_nxt = calc ? enc_bus.flag : flag_r;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      code_r <= 16'h0000;
    end else begin
      code_r <= code_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      flag_r <= AVE_F_OK;
    end else begin
      flag_r <= ave_flag_type'(flag_nxt);
    end
  end

  // Ready one edge ahead, so the source sees it before the taking edge
  wire conv_ready_nxt = (state_nxt == AVE_S_IDLE);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      conv_ready_r <= 1'b0;
    end else begin
      conv_ready_r <= conv_ready_nxt;
    end
  end

  // Result stage; the word stands until the next store
  wire store = (state_r == AVE_S_STORE);
  wire [CW-1:0] res_chan_nxt = store ? chan_r : res_chan_r;
  wire [15:0] res_word_nxt = store ? code_r : res_word_r;
  wire [1:0] res_flag_nxt = store ? flag_r : res_flag_r;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      res_valid_r <= 1'b0;
    end else begin
      res_valid_r <= store;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      res_chan_r <= '0;
    end else begin
      res_chan_r <= res_chan_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      res_word_r <= 16'h0000;
    end else begin
      res_word_r <= res_word_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      res_flag_r <= AVE_F_OK;
    end else begin
      res_flag_r <= ave_flag_type'(res_flag_nxt);
    end
  end

  // Per-channel process-image words
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    wire hit = (state_r == AVE_S_STORE) && (chan_r == CW'(i));
    always_ff @(posedge clock) begin
      if (!resetn) begin
        res_mem_r[i] <= 16'h0000;
        sign_bit_r[i] <= 1'b0;
      end else if (hit) begin
        res_mem_r[i] <= code_r;
        sign_bit_r[i] <= code_r[`AVE_SIGN_POS];
      end
    end
  end

  // Byte readout, one cycle after the select
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_byte;
    end
  end

  // Analog outputs: check the commanded word against its range
  for (genvar k = 0; k < NAO; k++) begin : g_ao
    wire signed [15:0] w = $signed(ao_word[k*16 +: 16]);
    wire [`AVE_RANGE_W-1:0] t = ao_type[k*`AVE_RANGE_W +: `AVE_RANGE_W];
    wire t_bip = (t == AVE_R_V_BIP) || (t == AVE_R_I_BIP);
    wire t_uni = (t == AVE_R_V_UNI) || (t == AVE_R_I_UNI) || (t == AVE_R_I_LZ);
    wire above = w > $signed(`AVE_CODE_OVR_MAX);
    wire below_bip = w < $signed(`AVE_CODE_UDR_BIP);
    wire below_uni = w < $signed(`AVE_CODE_ZERO);
    // outside range or inactive type gives zero
    wire out_bad = !(t_bip || t_uni) || above || (t_bip && below_bip) ||
      (t_uni && below_uni);
    wire [15:0] ao_dac_nxt = out_bad ? `AVE_CODE_ZERO : ao_word[k*16 +: 16];
    always_ff @(posedge clock) begin
      if (!resetn) begin
        ao_dac_r[k*16 +: 16] <= 16'h0000;
      end else begin
        ao_dac_r[k*16 +: 16] <= ao_dac_nxt;
      end
    end
    always_ff @(posedge clock) begin
      if (!resetn) begin
        // Outputs start blanked until a valid command arrives
        ao_zero_r[k] <= 1'b1;
      end else begin
        ao_zero_r[k] <= out_bad;
      end
    end
  end

  assign conv_ready = conv_ready_r;
  assign res_valid = res_valid_r;
  assign res_chan = res_chan_r;
  assign res_word = res_word_r;
  assign res_flag = res_flag_r;
  assign rd_data = rd_data_r;
  assign sign_bit = sign_bit_r;
  assign ao_dac = ao_dac_r;
  assign ao_zero = ao_zero_r;

endmodule : ave_top

/* sim/ave_props.sv */
// Port checks for the encoder top.
// Assumes a bind onto ave_top.
`timescale 1ns/1ps
module ave_props
  import ave_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NAO = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic conv_valid,
  input wire logic conv_ready,
  input wire logic [$clog2(NCH)-1:0] conv_chan,
  input wire logic [NCH-1:0] param_busy,
  input wire logic res_valid,
  input wire logic [$clog2(NCH)-1:0] res_chan,
  input wire logic [15:0] res_word,
  input ave_flag_type res_flag,
  input wire logic [NCH-1:0] sign_bit,
  input wire logic [NAO*16-1:0] ao_word,
  input wire logic [NAO*4-1:0] ao_type,
  input wire logic [NAO*16-1:0] ao_dac,
  input wire logic [NAO-1:0] ao_zero
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire take = conv_valid && conv_ready;
  chk_ready_gap: assert property (take |=> !conv_ready [*2])
    else $error("ready during calc");
  chk_result_lat: assert property (take |-> ##3 res_valid)
    else $error("result late");
  chk_sign_copy: assert property (res_valid |-> sign_bit[res_chan] == res_word[15])
    else $error("sign bit wrong");
  chk_low_zero: assert property (res_valid && res_flag == AVE_F_OK |-> res_word[3:0] == 4'h0)
    else $error("low bits set");
  chk_over_code: assert property (res_valid && res_flag == AVE_F_OVER |-> res_word == 16'h7fff)
    else $error("overflow code");
  chk_under_code: assert property (res_valid && res_flag == AVE_F_UNDER |-> res_word == 16'h8000)
    else $error("underflow code");
  chk_perr_code: assert property (take && param_busy[conv_chan] |-> ##3 res_word == 16'h7fff)
    else $error("param error code");
  chk_ovr_max: assert property (res_valid && res_flag == AVE_F_OK |-> $signed(res_word) <= 32511)
    else $error("above overdrive");
  chk_ao_blank: assert property (ao_type[3:0] == 4'h2 && ao_word[15] |=> ao_zero[0] && ao_dac[15:0] == 16'h0000)
    else $error("output not blanked");
endmodule : ave_props

/* sim/ave_reader.sv */
// Process image reader: fetches a stored word byte by byte.
// Assumes one-cycle registered readout.
`timescale 1ns/1ps
module ave_reader (
  input wire logic clock,
  output logic [1:0] rd_chan,
  output logic rd_byte_sel,
  input wire logic [7:0] rd_data
);
  initial rd_chan = 2'h0;
  initial rd_byte_sel = 1'b0;
  task read_word(input logic [1:0] ch, output logic [15:0] w);
    @(posedge clock);
    rd_chan <= ch;
    rd_byte_sel <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    w[15:8] = rd_data;
    @(posedge clock);
    rd_byte_sel <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    w[7:0] = rd_data;
  endtask : read_word
endmodule : ave_reader

/* sim/tb.sv */
// Self-checking bench for the encoder top.
// Assumes default parameters: 4 channels, 2 outputs, full scale 16384.
`timescale 1ns/1ps
module tb;
  import ave_pkg::*;
  logic clock = 0, resetn = 0, conv_valid = 0, conv_ready, res_valid, rd_byte_sel;
  logic [1:0] conv_chan = 0, res_chan, rd_chan, ao_zero;
  logic [15:0] conv_raw = 0, chan_range = 0, res_word;
  logic [3:0] param_busy = 0, sign_bit;
  logic [7:0] rd_data, ao_type = 0;
  logic [31:0] ao_word = 0, ao_dac;
  ave_flag_type res_flag;
  int miscompares = 0, checks = 0;
  int raws[12] = '{0, 16384, 8192, -16384, 19264, 19300, -19264, -19300, -2880, -2883,
    20000, -30000};
  always #50 clock = ~clock;
  ave_top ave_top_i (.clock, .resetn, .conv_valid, .conv_ready, .conv_chan, .conv_raw,
    .chan_range, .param_busy, .res_valid, .res_chan, .res_word, .res_flag, .rd_chan,
    .rd_byte_sel, .rd_data, .sign_bit, .ao_word, .ao_type, .ao_dac, .ao_zero);
  ave_reader ave_reader_i (.clock, .rd_chan, .rd_byte_sel, .rd_data);

  task cmp(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp

  // Flag in bits 17:16, word below
  function automatic logic [17:0] model(int rg, bit pe, int raw);
    longint v;
    if (pe || rg > 6) return {2'b11, 16'h7fff};
    if (rg == 0) return 18'h0;
    if (rg == 5) v = (longint'(raw - 16384 * 4 / 20) * 138240) >>> 16;
    else v = (longint'(raw) * 110592) >>> 16;
    if (v > 32511) return {2'b01, 16'h7fff};
    if (rg == 6 && v < 0) return 18'h0;
    if (v < ((rg == 1 || rg == 3) ? -32512 : -4864)) return {2'b10, 16'h8000};
    return {2'b00, v[15:0] & 16'hfff0};
  endfunction : model

  function automatic bit ao_ok(int t, logic signed [15:0] w);
    if (t == 1 || t == 3) return w >= -32512 && w <= 32511;
    return (t == 2 || t == 4 || t == 5) && w >= 0 && w <= 32511;
  endfunction : ao_ok

  task conv(int ch, int rg, bit pe, int raw);
    logic [17:0] x;
    logic [15:0] w;
    x = model(rg, pe, raw);
    @(posedge clock);
    chan_range[ch*4 +: 4] <= rg[3:0];
    param_busy[ch] <= pe;
    conv_chan <= ch[1:0];
    conv_raw <= raw[15:0];
    conv_valid <= 1'b1;
    @(negedge clock);
    for (int i = 0; i < 20 && !conv_ready; i++) @(negedge clock);
    @(posedge clock);
    conv_valid <= 1'b0;
    @(negedge clock);
    for (int i = 0; i < 8 && !res_valid; i++) @(negedge clock);
    cmp("res_valid", 16'h1, {15'h0, res_valid});
    cmp("chan", 16'(ch), {14'h0, res_chan});
    cmp("word", x[15:0], res_word);
    cmp("flag", {14'h0, x[17:16]}, {14'h0, res_flag});
    cmp("sign", {15'h0, x[15]}, {15'h0, sign_bit[ch]});
    ave_reader_i.read_word(ch[1:0], w);
    cmp("bytes", x[15:0], w);
  endtask : conv

  task ao_chk;
    logic [15:0] w[2];
    int t[2];
    @(posedge clock);
    for (int j = 0; j < 2; j++) begin
      w[j] = 16'($urandom);
      t[j] = $urandom % 8;
      ao_word[j*16 +: 16] <= w[j];
      ao_type[j*4 +: 4] <= t[j][3:0];
    end
    @(posedge clock);
    @(negedge clock);
    for (int j = 0; j < 2; j++) begin
      cmp("ao_dac", ao_ok(t[j], w[j]) ? w[j] : 16'h0, ao_dac[j*16 +: 16]);
      cmp("ao_zero", {15'h0, !ao_ok(t[j], w[j])}, {15'h0, ao_zero[j]});
    end
  endtask : ao_chk

  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    void'($urandom(23029));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    cmp("ao_zero_rst", 16'h3, {14'h0, ao_zero});
    foreach (raws[k]) for (int r = 0; r < 8; r++) conv(k % 4, r, 0, raws[k]);
    for (int r = 1; r < 7; r++) conv(r % 4, r, 1, 16384);
    repeat (20) conv($urandom % 4, $urandom % 7, 0, int'($urandom_range(65535)) - 32768);
    repeat (40) ao_chk();
    results();
  end

  initial begin
    #2000000;
    miscompares++;
    results();
  end
endmodule : tb

bind ave_top ave_props #(.NCH(NCH), .NAO(NAO)) ave_props_i (.clock, .resetn, .conv_valid,
  .conv_ready, .conv_chan, .param_busy, .res_valid, .res_chan, .res_word, .res_flag,
  .sign_bit, .ao_word, .ao_type, .ao_dac, .ao_zero);
